// [include/pgc_params.svh]
// Constants of the counter array: register addresses, field positions, codes and counts.
`ifndef PGC_PARAMS_SVH
`define PGC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PGC_ADDR_CTRL        8'hD8
`define PGC_ADDR_MODE        8'hD9
`define PGC_ADDR_MMODE0      8'hDA
`define PGC_ADDR_CNT_LO      8'hF9
`define PGC_ADDR_CNT_HI      8'hFA
`define PGC_ADDR_CMP_LO0     8'hE0
`define PGC_ADDR_CMP_HI0     8'hE1

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PGC_CTRL_OVF_BIT     7
`define PGC_CTRL_RUN_BIT     6
`define PGC_MODE_IDLE_BIT    7
`define PGC_MODE_TB_MSB      3
`define PGC_MODE_TB_LSB      1
`define PGC_MODE_OVF_IE_BIT  0

// ----------------------------------------------------------------------
// Timebase select codes
// ----------------------------------------------------------------------
`define PGC_TB_SYS_DIV12     3'h0
`define PGC_TB_SYS_DIV4      3'h1
`define PGC_TB_TIMER0        3'h2
`define PGC_TB_EXT_FALL      3'h3
`define PGC_TB_SYS           3'h4
`define PGC_TB_OSC_DIV8      3'h5

// ----------------------------------------------------------------------
// Divider counts and reset values
// ----------------------------------------------------------------------
`define PGC_SYS_DIV12        4'hC
`define PGC_SYS_DIV4         2'h3
`define PGC_OSC_DIV8         3'h7
`define PGC_NUM_MODULES      6
`define PGC_RESET_BYTE       8'h00
`define PGC_RESET_WORD       16'h0000
`define PGC_COUNT_TOP        16'hFFFF
`define PGC_LOW_TOP          8'hFF

`endif

// [include/pgc_pkg.sv]
// Types shared by the counter array and its capture/compare units.
package pgc_pkg;

   // -------------------------------------------------------------------
   // Per-module mode byte, bit 7 down to bit 0
   // -------------------------------------------------------------------
   typedef struct packed {
      logic wide_pwm_select;
      logic compare_enable;
      logic rise_capture_enable;
      logic fall_capture_enable;
      logic match_enable;
      logic toggle_enable;
      logic pwm_enable;
      logic module_irq_enable;
   } pgc_mode_type;

   // -------------------------------------------------------------------
   // Special function register access from the processor
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } pgc_sfr_req_type;

   // -------------------------------------------------------------------
   // Counter state broadcast to every module
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] count;
      logic        advanced;
      logic        low_wrap;
      logic        full_wrap;
      logic        active;
   } pgc_time_type;

endpackage

// [rtl/pgc_cc_unit.sv]
// One capture/compare module of the counter array.
`timescale 1ns/10ps
`include "pgc_params.svh"

module pgc_cc_unit
(
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_srst,
   input  wire pgc_pkg::pgc_time_type i_time,
   input  wire pgc_pkg::pgc_mode_type i_mode,
   input  wire logic                 i_line,
   input  wire logic                 i_wr_lo,
   input  wire logic                 i_wr_hi,
   input  wire logic [7:0]           i_wdata,
   output logic      [15:0]          o_compare,
   output logic                      o_event,
   output logic                      o_line,
   output logic                      o_drive
);
   import pgc_pkg::*;

   logic line_q;
   logic line_level;
   logic line_prev;
   logic capture_mode;
   logic match_mode;
   logic freq_mode;
   logic pwm8_mode;
   logic wide_pwm_select_mode;
   logic hit16;
   logic hit8;
   logic capture_hit;

   // -------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------
   assign capture_mode = (i_mode.rise_capture_enable | i_mode.fall_capture_enable)
                         & ~i_mode.match_enable & ~i_mode.toggle_enable
                         & ~i_mode.pwm_enable;
   assign match_mode   = i_mode.compare_enable & i_mode.match_enable
                         & ~i_mode.pwm_enable;
   assign freq_mode    = i_mode.compare_enable & i_mode.toggle_enable
                         & i_mode.pwm_enable & ~i_mode.match_enable;
   assign pwm8_mode    = i_mode.compare_enable & i_mode.pwm_enable & ~i_mode.toggle_enable
                         & ~i_mode.match_enable & ~i_mode.wide_pwm_select;
   assign wide_pwm_select_mode   = i_mode.compare_enable & i_mode.pwm_enable & ~i_mode.toggle_enable
                         & ~i_mode.match_enable & i_mode.wide_pwm_select;

   assign hit16 = i_time.advanced & (i_time.count == o_compare);
   assign hit8  = i_time.advanced & (i_time.count[7:0] == o_compare[7:0]);

   // -------------------------------------------------------------------
   // Line filter: a level counts only once seen on two successive edges
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         line_q     <= 1'b0;
         line_level <= 1'b0;
         line_prev  <= 1'b0;
      end
      else
      begin
         line_q <= i_line;
         if (i_line == line_q)
            line_level <= i_line;
         line_prev <= line_level;
      end
   end

   assign capture_hit = i_time.active & capture_mode
                        & ((i_mode.rise_capture_enable & line_level & ~line_prev)
                        | (i_mode.fall_capture_enable & ~line_level & line_prev));

   // -------------------------------------------------------------------
   // Compare register; hardware updates take priority over writes
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_compare <= `PGC_RESET_WORD;
      else if (capture_hit)
         o_compare <= i_time.count;
      else if (freq_mode & hit8)
         // A high byte of zero adds nothing, so the next match is 256 ticks on.
         o_compare[7:0] <= o_compare[7:0] + o_compare[15:8];
      else if (pwm8_mode & i_time.low_wrap)
         o_compare[7:0] <= i_time.count[15:8];
      else
      begin
         if (i_wr_lo)
            o_compare[7:0] <= i_wdata;
         if (i_wr_hi)
            o_compare[15:8] <= i_wdata;
      end
   end

   // -------------------------------------------------------------------
   // Output line and event pulse
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_line <= 1'b0;
      else if ((freq_mode & hit8) | (match_mode & i_mode.toggle_enable & hit16))
         o_line <= ~o_line;
      else if (pwm8_mode & i_time.low_wrap)
         // The wrap cycle is also a match when the reloaded value is zero.
         o_line <= (i_time.count[15:8] == `PGC_RESET_BYTE);
      else if (pwm8_mode & hit8)
         o_line <= 1'b1;
      else if (wide_pwm_select_mode & i_time.full_wrap)
         o_line <= (o_compare == `PGC_RESET_WORD);
      else if (wide_pwm_select_mode & hit16)
         o_line <= 1'b1;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_event <= 1'b0;
         o_drive <= 1'b0;
      end
      else
      begin
         o_event <= capture_hit | ((match_mode | wide_pwm_select_mode) & hit16);
         o_drive <= i_mode.compare_enable & (i_mode.toggle_enable | i_mode.pwm_enable);
      end
   end

endmodule

// [rtl/pgc_counter_array.sv]
// Counter array top: timebase, 16-bit counter, register file and six modules.
//
// Summary of operation
// - Three-bit select picks one of six timebases.
// - Oscillator synchronised before dividing and advancing counter.
// - Low-byte read snapshots high byte for later.
// - Counter reads never disturb counting.
// - Wrap sets overflow flag; enable gates request.
// - Overflow flag cleared only by software write.
// - Requests need global and group enables.
// - Idle without suspend keeps everything running.
// - One counter shared by six independent modules.
// - Mode bits decode into five operating modes.
// - Module flag requests only with its enable.
// - Capture copies counter on selected line edge.
// - Capture sets module flag until software clears.
// - Line levels count only after two cycles.
// - Timer match sets module flag and request.
// - High-speed output toggles line on match.
// - Frequency output toggles, adds high to low.
// - Zero high byte means 256-tick half period.
// - 8-bit PWM: high on match, low on wrap.
// - 8-bit PWM reloads low compare on wrap.
// - 16-bit PWM: high on match, low on wrap.
// - Idle with suspend halts counter and modules.
// - Counter advances only while run bit set.
`timescale 1ns/10ps
`include "pgc_params.svh"

module pgc_counter_array
(
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_srst,
   input  wire pgc_pkg::pgc_sfr_req_type i_sfr,
   output logic      [7:0]              o_sfr_rdata,
   input  wire logic                    i_idle,
   input  wire logic                    i_global_irq_enable,
   input  wire logic                    i_group_irq_enable,
   input  wire logic                    i_timer0_overflow,
   input  wire logic                    i_external_count_input,
   input  wire logic                    i_ext_osc_clk,
   input  wire logic [5:0]              i_module_io_line,
   output logic      [5:0]              o_module_io_line,
   output logic      [5:0]              o_module_io_oe,
   output logic                         o_irq
);
   import pgc_pkg::*;

   localparam int NUM = `PGC_NUM_MODULES;

   logic [15:0]      counter;
   logic [7:0]       snapshot;
   logic             counter_run;
   logic             counter_overflow_flag;
   logic [5:0]       module_event_flag;
   logic             idle_suspend;
   logic [2:0]       timebase_select;
   logic             overflow_irq_enable;
   pgc_mode_type     module_mode [NUM];
   logic [15:0]      module_compare [NUM];
   logic [5:0]       module_event;
   logic [5:0]       module_irq_enable;
   logic [5:0]       io_meta;
   logic [5:0]       io_sync;
   logic [2:0]       eci_sync;
   logic [2:0]       osc_sync;
   logic [3:0]       div12;
   logic [1:0]       div4;
   logic [2:0]       osc_div;
   logic             osc_tick;
   logic             source_tick;
   logic             active;
   logic             tick;
   logic             advanced;
   logic             low_wrap;
   logic             full_wrap;
   logic             wr_ctrl;
   logic             wr_mode;
   logic             wr_cnt_lo;
   logic             wr_cnt_hi;
   logic [7:0]       next_rdata;
   pgc_time_type     time_bus;

   // -------------------------------------------------------------------
   // Address decode helpers
   // -------------------------------------------------------------------
   function automatic logic is_mode_addr(input logic [7:0] addr, input int n);
      is_mode_addr = (addr == (`PGC_ADDR_MMODE0 + 8'(n)));
   endfunction

   function automatic logic is_cmp_addr(input logic [7:0] addr, input logic [7:0] base,
                                        input int n);
      is_cmp_addr = (addr == (base + 8'(2 * n)));
   endfunction

   assign wr_ctrl   = i_sfr.wr & (i_sfr.addr == `PGC_ADDR_CTRL);
   assign wr_mode   = i_sfr.wr & (i_sfr.addr == `PGC_ADDR_MODE);
   assign wr_cnt_lo = i_sfr.wr & (i_sfr.addr == `PGC_ADDR_CNT_LO);
   assign wr_cnt_hi = i_sfr.wr & (i_sfr.addr == `PGC_ADDR_CNT_HI);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   // Stage zero of each chain feeds only stage one; edge logic looks later.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         io_meta  <= 6'h00;
         io_sync  <= 6'h00;
         eci_sync <= 3'h0;
         osc_sync <= 3'h0;
      end
      else
      begin
         io_meta  <= i_module_io_line;
         io_sync  <= io_meta;
         eci_sync <= {eci_sync[1:0], i_external_count_input};
         osc_sync <= {osc_sync[1:0], i_ext_osc_clk};
      end
   end

   // -------------------------------------------------------------------
   // Timebase
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         div12   <= 4'h0;
         div4    <= 2'h0;
         osc_div <= 3'h0;
      end
      else
      begin
         div12 <= (div12 == (`PGC_SYS_DIV12 - 4'h1)) ? 4'h0 : div12 + 4'h1;
         div4  <= div4 + 2'h1;
         if (osc_sync[1] & ~osc_sync[2])
            osc_div <= osc_div + 3'h1;
      end
   end

   assign osc_tick = osc_sync[1] & ~osc_sync[2] & (osc_div == `PGC_OSC_DIV8);

   always_comb
   begin
      unique case (timebase_select)
         `PGC_TB_SYS_DIV12: source_tick = (div12 == 4'h0);
         `PGC_TB_SYS_DIV4:  source_tick = (div4 == `PGC_SYS_DIV4);
         `PGC_TB_TIMER0:    source_tick = i_timer0_overflow;
         // Edges closer than two clocks would merge in the synchroniser.
         `PGC_TB_EXT_FALL:  source_tick = ~eci_sync[1] & eci_sync[2];
         `PGC_TB_SYS:       source_tick = 1'b1;
         `PGC_TB_OSC_DIV8:  source_tick = osc_tick;
         default:           source_tick = 1'b0;
      endcase
   end

   assign active = ~(idle_suspend & i_idle);
   assign tick   = source_tick & counter_run & active;

   // -------------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         counter <= `PGC_RESET_WORD;
      else if (wr_cnt_lo)
         counter[7:0] <= i_sfr.wdata;
      else if (wr_cnt_hi)
         counter[15:8] <= i_sfr.wdata;
      else if (tick)
         counter <= counter + 16'h0001;
   end

   // The modules see the counter one edge after it moved.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         advanced  <= 1'b0;
         low_wrap  <= 1'b0;
         full_wrap <= 1'b0;
      end
      else
      begin
         advanced  <= tick & ~wr_cnt_lo & ~wr_cnt_hi;
         low_wrap  <= tick & ~wr_cnt_lo & ~wr_cnt_hi & (counter[7:0] == `PGC_LOW_TOP);
         full_wrap <= tick & ~wr_cnt_lo & ~wr_cnt_hi & (counter == `PGC_COUNT_TOP);
      end
   end

   assign time_bus.count     = counter;
   assign time_bus.advanced  = advanced;
   assign time_bus.low_wrap  = low_wrap;
   assign time_bus.full_wrap = full_wrap;
   assign time_bus.active    = active;

   // -------------------------------------------------------------------
   // Control and mode registers
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         counter_run         <= 1'b0;
         idle_suspend        <= 1'b0;
         timebase_select     <= `PGC_TB_SYS_DIV12;
         overflow_irq_enable <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            counter_run <= i_sfr.wdata[`PGC_CTRL_RUN_BIT];
         if (wr_mode)
         begin
            idle_suspend        <= i_sfr.wdata[`PGC_MODE_IDLE_BIT];
            timebase_select     <= i_sfr.wdata[`PGC_MODE_TB_MSB:`PGC_MODE_TB_LSB];
            overflow_irq_enable <= i_sfr.wdata[`PGC_MODE_OVF_IE_BIT];
         end
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         counter_overflow_flag <= 1'b0;
         module_event_flag     <= 6'h00;
      end
      else
      begin
         counter_overflow_flag <= full_wrap
                                  | (wr_ctrl ? i_sfr.wdata[`PGC_CTRL_OVF_BIT]
                                             : counter_overflow_flag);
         module_event_flag <= module_event
                              | (wr_ctrl ? i_sfr.wdata[5:0] : module_event_flag);
      end
   end

   // -------------------------------------------------------------------
   // Capture/compare modules
   // -------------------------------------------------------------------
   generate
      for (genvar n = 0; n < NUM; n++)
      begin : g_unit
         always_ff @(posedge i_sys_clk)
         begin
            if (i_srst)
               module_mode[n] <= pgc_mode_type'(`PGC_RESET_BYTE);
            else if (i_sfr.wr & is_mode_addr(i_sfr.addr, n))
               module_mode[n] <= pgc_mode_type'(i_sfr.wdata);
         end

         assign module_irq_enable[n] = module_mode[n].module_irq_enable;

         pgc_cc_unit u_unit
         (
            .i_sys_clk (i_sys_clk),
            .i_srst    (i_srst),
            .i_time    (time_bus),
            .i_mode    (module_mode[n]),
            .i_line    (io_sync[n]),
            .i_wr_lo   (i_sfr.wr & is_cmp_addr(i_sfr.addr, `PGC_ADDR_CMP_LO0, n)),
            .i_wr_hi   (i_sfr.wr & is_cmp_addr(i_sfr.addr, `PGC_ADDR_CMP_HI0, n)),
            .i_wdata   (i_sfr.wdata),
            .o_compare (module_compare[n]),
            .o_event   (module_event[n]),
            .o_line    (o_module_io_line[n]),
            .o_drive   (o_module_io_oe[n])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // Interrupt request
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_irq <= 1'b0;
      else
         o_irq <= i_global_irq_enable & i_group_irq_enable
                  & ((counter_overflow_flag & overflow_irq_enable)
                  | (|(module_event_flag & module_irq_enable)));
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   always_comb
   begin
      next_rdata = `PGC_RESET_BYTE;
      if (i_sfr.addr == `PGC_ADDR_CTRL)
         next_rdata = {counter_overflow_flag, counter_run, module_event_flag};
      else if (i_sfr.addr == `PGC_ADDR_MODE)
         next_rdata = {idle_suspend, 3'h0, timebase_select, overflow_irq_enable};
      else if (i_sfr.addr == `PGC_ADDR_CNT_LO)
         next_rdata = counter[7:0];
      else if (i_sfr.addr == `PGC_ADDR_CNT_HI)
         next_rdata = snapshot;
      for (int n = 0; n < NUM; n++)
      begin
         if (is_mode_addr(i_sfr.addr, n))
            next_rdata = module_mode[n];
         if (is_cmp_addr(i_sfr.addr, `PGC_ADDR_CMP_LO0, n))
            next_rdata = module_compare[n][7:0];
         if (is_cmp_addr(i_sfr.addr, `PGC_ADDR_CMP_HI0, n))
            next_rdata = module_compare[n][15:8];
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_sfr_rdata <= `PGC_RESET_BYTE;
         snapshot    <= `PGC_RESET_BYTE;
      end
      else
      begin
         if (i_sfr.rd)
            o_sfr_rdata <= next_rdata;
         if (i_sfr.rd & (i_sfr.addr == `PGC_ADDR_CNT_LO))
            snapshot <= counter[15:8];
      end
   end

endmodule

// [testbench/pgc_chk.sv]
// Port checker of the counter array.
`timescale 1ns/10ps
module pgc_chk
(
   input wire logic                     i_sys_clk,
   input wire logic                     i_srst,
   input wire pgc_pkg::pgc_sfr_req_type i_sfr,
   input wire logic [7:0]               o_sfr_rdata,
   input wire logic                     i_global_irq_enable,
   input wire logic                     i_group_irq_enable,
   input wire logic [5:0]               o_module_io_line,
   input wire logic [5:0]               o_module_io_oe,
   input wire logic                     o_irq
);
   import pgc_pkg::*;
   logic en;
   assign en = i_global_irq_enable & i_group_irq_enable;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_reset; disable iff (1'b0) i_srst |=> !o_irq && o_module_io_oe == 6'h00; endproperty
   property p_irq_gate; o_irq |-> $past(en); endproperty
   property p_irq_drop; !en |=> !o_irq; endproperty
   property p_irq_keep; o_irq && en && !i_sfr.wr && !$past(i_sfr.wr) |=> o_irq; endproperty
   property p_rd_hold; !i_sfr.rd |=> $stable(o_sfr_rdata); endproperty
   property p_mode_rsv; i_sfr.rd && i_sfr.addr == 8'hD9 |=> o_sfr_rdata[6:4] == 3'h0; endproperty
   property p_unmapped; i_sfr.rd && i_sfr.addr == 8'h00 |=> o_sfr_rdata == 8'h00; endproperty
   property p_oe_cause; $changed(o_module_io_oe) |-> $past(i_sfr.wr) || $past(i_sfr.wr, 2);
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared");
   a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
   a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped");
   a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_mode_rsv: assert property (p_mode_rsv) else $error("reserved bits set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
   c_irq: cover property (o_irq);
   c_oe: cover property (o_module_io_oe != 6'h00);
   c_hi: cover property (i_sfr.rd && i_sfr.addr == 8'hFA);
endmodule

// [testbench/pgc_far_model.sv]
// Far-side model: module lines, count input and external oscillator.
`timescale 1ns/10ps
module pgc_far_model
(
   input  wire logic       i_clk,
   input  wire logic [5:0] i_req,
   output logic      [5:0] o_line = 6'h00,
   output logic            o_count = 1'b0,
   output logic            o_osc = 1'b0
);
   logic [1:0] ph = 2'h0;
   // The oscillator runs free but slower than half the clock, so it can be synchronised.
   always #9.3 o_osc = ~o_osc;
   always @(posedge i_clk)
   begin
      ph <= ph + 2'h1;
      o_count <= ph[1];
      if (ph[0])
         o_line <= i_req;
   end
endmodule

// [testbench/programmable_counter_array_bench.sv]
// Self-checking bench of the counter array.
`timescale 1ns/10ps
module programmable_counter_array_bench;
   import pgc_pkg::*;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pgc_row_type;
   logic            sys_clk = 1'b0;
   logic            srst = 1'b1;
   pgc_sfr_req_type sfr = '0;
   logic            idle = 1'b0;
   logic            grp = 1'b1, gie = 1'b1;
   logic            t0 = 1'b0;
   logic [5:0]      req = 6'h00;
   logic [7:0]      rdata, v0, v1;
   logic [5:0]      far, line, oline, oe;
   logic            cnt_in, osc, irq;
   int              errors = 0;
   int              comparisons = 0;
   int              cyc = 0;
   pgc_row_type     rows [8] = '{{1'b0, 8'hD8, 8'h00, 8'h00}, {1'b0, 8'hD9, 8'h00, 8'h00},
      {1'b0, 8'hF9, 8'h00, 8'h00}, {1'b0, 8'hFA, 8'h00, 8'h00}, {1'b1, 8'hD9, 8'hFF, 8'h8F},
      {1'b1, 8'hDA, 8'hCC, 8'hCC}, {1'b1, 8'hE1, 8'h5A, 8'h5A}, {1'b1, 8'h00, 8'hAA, 8'h00}};
   logic [7:0]      tb_exp [9] = '{8'h08, 8'h18, 8'h10, 8'h18, 8'h60, 8'h05, 8'h00, 8'h00, 8'h60};
   always #4 sys_clk = ~sys_clk;
   // A driving module wins the shared pin; otherwise the far side sets its level.
   assign line = (oe & oline) | (~oe & far);
   pgc_counter_array u_pgc_counter_array (.i_sys_clk(sys_clk), .i_srst(srst), .i_sfr(sfr),
      .o_sfr_rdata(rdata), .i_idle(idle), .i_global_irq_enable(gie), .i_group_irq_enable(grp),
      .i_timer0_overflow(t0), .i_external_count_input(cnt_in), .i_ext_osc_clk(osc),
      .i_module_io_line(line), .o_module_io_line(oline), .o_module_io_oe(oe), .o_irq(irq));
   pgc_far_model u_pgc_far_model (.i_clk(sys_clk), .i_req(req), .o_line(far), .o_count(cnt_in),
      .o_osc(osc));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr <= {a, 1'b1, 1'b0, d};
      @(posedge sys_clk);
      sfr <= '0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr <= {a, 1'b0, 1'b1, 8'h00};
      @(posedge sys_clk);
      sfr <= '0;
      @(posedge sys_clk);
      d = rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      cmp($sformatf("reg %h", a), e, d);
   endtask
   // The ceiling is about five times the length of the whole sequence.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      t0 <= (cyc % 6 == 0);
      if (cyc == 6000)
      begin
         errors++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      wr(8'hD8, 8'h40);
      for (int c = 0; c < 9; c++)
      begin
         wr(8'hD9, {c == 7, 3'h0, c > 6 ? 3'h4 : c[2:0], 1'b0});
         idle <= (c > 6);
         rd(8'hF9, v0);
         repeat (94) @(posedge sys_clk);
         rd(8'hF9, v1);
         v1 = v1 - v0;
         if (c == 5 && v1 inside {[8'h04:8'h06]})
            v1 = 8'h05;
         cmp("ticks", tb_exp[c], v1);
      end
      idle <= 1'b0;
      wr(8'hD9, 8'h08);
      wr(8'hD8, 8'h00);
      wr(8'hF9, 8'h34);
      wr(8'hFA, 8'h12);
      rc(8'hF9, 8'h34);
      wr(8'hFA, 8'h56);
      rc(8'hFA, 8'h12);
      rc(8'hF9, 8'h34);
      rc(8'hFA, 8'h56);
      wr(8'hDB, 8'h21);
      req <= 6'h02;
      repeat (12) @(posedge sys_clk);
      rc(8'hE2, 8'h34);
      rc(8'hE3, 8'h56);
      rc(8'hD8, 8'h02);
      cmp("irq", 8'h01, {7'h00, irq});
      wr(8'hD8, 8'h00);
      repeat (3) @(posedge sys_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      wr(8'hE0, 8'h10);
      wr(8'hE1, 8'h00);
      wr(8'hDA, 8'h4C);
      wr(8'hF9, 8'h00);
      wr(8'hFA, 8'h00);
      wr(8'hD8, 8'h40);
      repeat (30) @(posedge sys_clk);
      cmp("hso", 8'h03, {6'h00, oe[0], oline[0]});
      rc(8'hD8, 8'h41);
      wr(8'hD8, 8'h00);
      wr(8'hDA, 8'h00);
      wr(8'hF9, 8'hF0);
      wr(8'hFA, 8'hFF);
      wr(8'hD9, 8'h09);
      wr(8'hD8, 8'h40);
      repeat (30) @(posedge sys_clk);
      rc(8'hD8, 8'hC0);
      grp <= 1'b0;
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      grp <= 1'b1;
      gie <= 1'b0;
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      gie <= 1'b1;
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h01, {7'h00, irq});
      wr(8'hD8, 8'h40);
      repeat (2) @(posedge sys_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      wr(8'hD8, 8'h00);
      wr(8'hF9, 8'hF0);
      wr(8'hFA, 8'h05);
      wr(8'hDC, 8'h42);
      wr(8'hE6, 8'hF4);
      wr(8'hE7, 8'h04);
      wr(8'hDD, 8'h46);
      wr(8'hE8, 8'hF8);
      wr(8'hDE, 8'h46);
      wr(8'hEB, 8'h06);
      wr(8'hDF, 8'hC2);
      wr(8'hD8, 8'h40);
      repeat (28) @(posedge sys_clk);
      wr(8'hD9, 8'h0C);
      rc(8'hE4, 8'h06);
      rc(8'hE6, 8'h10);
      rc(8'hE8, 8'hF8);
      rc(8'hD8, 8'h60);
      cmp("pwm", 8'h3C, {2'h0, oe & oline});
      report_and_stop();
   end
endmodule
bind pgc_counter_array pgc_chk u_pgc_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_sfr(i_sfr),
   .o_sfr_rdata(o_sfr_rdata), .i_global_irq_enable(i_global_irq_enable),
   .i_group_irq_enable(i_group_irq_enable), .o_module_io_line(o_module_io_line),
   .o_module_io_oe(o_module_io_oe), .o_irq(o_irq));
